// ==== hdl/pmt_power_mode_fsm.sv ====
`timescale 1ns/10ps

module pmt_power_mode_fsm #(
	parameter int TRDEL_STEP_CYCLES = pmt_pkg::TRDEL_STEP_CYC,
	parameter int POR_DELAY_CYCLES = pmt_pkg::POR_DELAY_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [pmt_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic host_select_line_i,
	input wire logic edge_wake_input_i,
	input wire logic level_rouse_input_i,
	input wire logic cur_below_thr_i,
	input wire logic fault_toggle_input_i,
	input wire logic ctrl_reg_up_i,
	input wire logic wake_timer_exp_i,
	output logic reset_output_o,
	output logic safe_state_out_a_o,
	output logic safe_state_out_b_o,
	output logic alert_output_o,
	output logic supervision_en_o,
	output logic regulators_on_o,
	output logic keepalive_regulator_on_o
);

	// ----------------------------------------------------------------
	// state record
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] sel_sy;
		logic [2:0] ewk_sy;
		logic [1:0] lvl_sy;
		logic [1:0] cur_sy;
		logic [2:0] flt_sy;
		logic [1:0] rup_sy;
		logic [1:0] wkt_sy;
		pmt_pkg::pmt_state_t state;
		logic [pmt_pkg::TIMER_W-1:0] timer;
		logic [pmt_pkg::CMD_W-1:0] cmd;
		logic curmon;
		logic wktmr_en;
		logic keep_cfg;
		logic [pmt_pkg::TRDEL_W-1:0] trdel;
		logic [1:0] flt_cnt;
		logic [1:0] cause;
		logic rst_out;
		logic ssa;
		logic ssb;
		logic alert;
		logic sup_en;
		logic regs_on;
		logic keep_on;
		logic ack;
		logic [31:0] dat;
	} pmt_regs_t;

	pmt_regs_t s_q;
	pmt_regs_t s_d;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// last timer value of the transition delay for a delay code
	function automatic logic [pmt_pkg::TIMER_W-1:0] trdel_last(
		input logic [pmt_pkg::TRDEL_W-1:0] code
	);
		logic [pmt_pkg::TIMER_W+3:0] prod;
		prod = ({{pmt_pkg::TIMER_W{1'b0}}, code} + 1'b1)
			* (pmt_pkg::TIMER_W+4)'(TRDEL_STEP_CYCLES);
		return pmt_pkg::TIMER_W'(prod - 1'b1);
	endfunction

	// rising edge of a synchronised level and its delayed copy
	function automatic logic rise(input logic now, input logic prev);
		return now & ~prev;
	endfunction

	logic sel_rise;
	logic ewk_rise;
	logic flt_rise;
	logic wake_evt;
	logic tr_expired;
	logic por_done;
	logic [pmt_pkg::TIMER_W-1:0] timer_inc;

	// ----------------------------------------------------------------
	// event decode from synchronised inputs
	// ----------------------------------------------------------------
	always_comb begin
		sel_rise = rise(s_q.sel_sy[1], s_q.sel_sy[2]);
		ewk_rise = rise(s_q.ewk_sy[1], s_q.ewk_sy[2]);
		flt_rise = rise(s_q.flt_sy[1], s_q.flt_sy[2]);
		wake_evt = ewk_rise | s_q.lvl_sy[1];
		tr_expired = s_q.timer >= trdel_last(s_q.trdel);
		por_done = s_q.timer >=
			pmt_pkg::TIMER_W'(POR_DELAY_CYCLES - 1);
		timer_inc = s_q.timer + 1'b1;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [pmt_pkg::CMD_W-1:0] act_cmd;
		s_d = s_q;
		act_cmd = pmt_pkg::CMD_NONE;

		// two flops per outside input, third stage for edges
		s_d.sel_sy = {s_q.sel_sy[1:0], host_select_line_i};
		s_d.ewk_sy = {s_q.ewk_sy[1:0], edge_wake_input_i};
		s_d.lvl_sy = {s_q.lvl_sy[0], level_rouse_input_i};
		s_d.cur_sy = {s_q.cur_sy[0], cur_below_thr_i};
		s_d.flt_sy = {s_q.flt_sy[1:0], fault_toggle_input_i};
		s_d.rup_sy = {s_q.rup_sy[0], ctrl_reg_up_i};
		s_d.wkt_sy = {s_q.wkt_sy[0], wake_timer_exp_i};
		s_d.alert = 1'b0;

		// pending command is consumed only at the select edge
		if (sel_rise) begin
			act_cmd = s_q.cmd;
			s_d.cmd = pmt_pkg::CMD_NONE;
		end

		// transition timer runs in every timed state
		s_d.timer = timer_inc;

		unique case (s_q.state)
			pmt_pkg::PMT_INIT: begin
				s_d.ssa = 1'b0;
				s_d.ssb = 1'b0;
				s_d.regs_on = 1'b1;
				s_d.keep_on = 1'b1;
				s_d.sup_en = 1'b1;
				// delay counts once the last regulator is up
				if (!s_q.rup_sy[1] || s_q.rst_out) begin
					s_d.timer = '0;
				end else if (por_done) begin
					s_d.rst_out = 1'b1;
				end
				if (act_cmd == pmt_pkg::CMD_NORMAL && s_q.rst_out) begin
					s_d.state = pmt_pkg::PMT_NORMAL;
					s_d.ssa = 1'b1;
					s_d.ssb = 1'b1;
				end
			end
			pmt_pkg::PMT_NORMAL: begin
				s_d.timer = '0;
				if (act_cmd == pmt_pkg::CMD_SLEEP) begin
					s_d.state = pmt_pkg::PMT_TO_SLEEP;
					s_d.ssa = 1'b0;
					s_d.ssb = 1'b0;
					s_d.sup_en = 1'b0;
				end else if (act_cmd == pmt_pkg::CMD_STANDBY) begin
					s_d.state = pmt_pkg::PMT_TO_STANDBY;
					s_d.ssa = 1'b0;
					s_d.ssb = 1'b0;
					s_d.sup_en = 1'b0;
				end
			end
			pmt_pkg::PMT_WAKE: begin
				s_d.timer = '0;
				// count toggle periods; wake inputs are not looked at
				if (flt_rise && s_q.flt_cnt != pmt_pkg::FLT_MIN_PERIODS) begin
					s_d.flt_cnt = s_q.flt_cnt + 1'b1;
				end
				if (act_cmd == pmt_pkg::CMD_SLEEP) begin
					s_d.state = pmt_pkg::PMT_TO_SLEEP;
					s_d.sup_en = 1'b0;
				end else if (act_cmd == pmt_pkg::CMD_STANDBY) begin
					s_d.state = pmt_pkg::PMT_TO_STANDBY;
					s_d.sup_en = 1'b0;
				end else if (act_cmd == pmt_pkg::CMD_NORMAL) begin
					// the command moves to NORMAL only once FLT_MIN_PERIODS toggle periods are counted
					if (s_q.flt_cnt == pmt_pkg::FLT_MIN_PERIODS) begin
						s_d.state = pmt_pkg::PMT_NORMAL;
						s_d.ssa = 1'b1;
						s_d.ssb = 1'b1;
					end else begin
						s_d.cause = pmt_pkg::CAUSE_REFUSED;
					end
				end
			end
			pmt_pkg::PMT_TO_SLEEP: begin
				// reset is held high and safe outputs held low
				s_d.rst_out = 1'b1;
				s_d.ssa = 1'b0;
				s_d.ssb = 1'b0;
				if (wake_evt) begin
					s_d.state = pmt_pkg::PMT_WAKE;
					s_d.alert = 1'b1;
					s_d.cause = pmt_pkg::CAUSE_WAKE;
				end else if (s_q.curmon && s_q.cur_sy[1]) begin
					s_d.state = pmt_pkg::PMT_SLEEP;
				end else if (tr_expired) begin
					if (s_q.curmon) begin
						s_d.state = pmt_pkg::PMT_WAKE;
						s_d.alert = 1'b1;
						s_d.cause = pmt_pkg::CAUSE_CURRENT;
					end else begin
						s_d.state = pmt_pkg::PMT_SLEEP;
					end
				end
				// a fresh WAKE restarts supervision and toggle count
				if (s_d.state == pmt_pkg::PMT_WAKE) begin
					s_d.sup_en = 1'b1;
					s_d.flt_cnt = 2'h0;
				end
			end
			pmt_pkg::PMT_SLEEP: begin
				s_d.timer = '0;
				if (wake_evt || !s_q.cur_sy[1]
					|| (s_q.wktmr_en && s_q.wkt_sy[1])
					|| act_cmd == pmt_pkg::CMD_WAKE) begin
					s_d.state = pmt_pkg::PMT_WAKE;
					s_d.alert = 1'b1;
					s_d.sup_en = 1'b1;
					s_d.flt_cnt = 2'h0;
				end
			end
			pmt_pkg::PMT_TO_STANDBY: begin
				s_d.ssa = 1'b0;
				s_d.ssb = 1'b0;
				if (wake_evt) begin
					s_d.state = pmt_pkg::PMT_INIT;
					s_d.rst_out = 1'b0;
					s_d.cause = pmt_pkg::CAUSE_WAKE;
				end else if (s_q.curmon && s_q.cur_sy[1]) begin
					s_d.state = pmt_pkg::PMT_STANDBY;
					s_d.rst_out = 1'b0;
					s_d.regs_on = 1'b0;
					s_d.keep_on = s_q.keep_cfg;
				end else if (tr_expired) begin
					s_d.rst_out = 1'b0;
					if (s_q.curmon) begin
						s_d.state = pmt_pkg::PMT_INIT;
						s_d.cause = pmt_pkg::CAUSE_CURRENT;
					end else begin
						s_d.state = pmt_pkg::PMT_STANDBY;
						s_d.regs_on = 1'b0;
						s_d.keep_on = s_q.keep_cfg;
					end
				end
				if (s_d.state == pmt_pkg::PMT_INIT) begin
					s_d.timer = '0;
					s_d.sup_en = 1'b1;
				end
			end
			pmt_pkg::PMT_STANDBY: begin
				s_d.timer = '0;
				s_d.rst_out = 1'b0;
				s_d.ssa = 1'b0;
				s_d.ssb = 1'b0;
				s_d.keep_on = s_q.keep_cfg;
				if (wake_evt || (s_q.wktmr_en && s_q.wkt_sy[1])) begin
					s_d.state = pmt_pkg::PMT_INIT;
					s_d.regs_on = 1'b1;
					s_d.keep_on = 1'b1;
					s_d.sup_en = 1'b1;
				end
			end
		endcase

		// wishbone slave, one wait state, unmapped reads as zero
		s_d.ack = wb_cyc_i & wb_stb_i & ~s_q.ack;
		s_d.dat = 32'h0000_0000;
		if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
			if (wb_we_i && wb_sel_i[0]) begin
				unique case (wb_adr_i)
					pmt_pkg::ADR_CTRL: begin
						s_d.curmon = wb_dat_i[pmt_pkg::CTRL_CURMON_BIT];
						s_d.wktmr_en = wb_dat_i[pmt_pkg::CTRL_WKTMR_BIT];
						s_d.keep_cfg = wb_dat_i[pmt_pkg::CTRL_KEEP_BIT];
						s_d.trdel = wb_dat_i[pmt_pkg::CTRL_TRDEL_LSB +:
							pmt_pkg::TRDEL_W];
					end
					pmt_pkg::ADR_CMD: begin
						// a write beats the consume in the same cycle
						s_d.cmd = wb_dat_i[pmt_pkg::CMD_W-1:0];
					end
					default: begin
					end
				endcase
			end
			unique case (wb_adr_i)
				pmt_pkg::ADR_CTRL: begin
					s_d.dat[pmt_pkg::CTRL_CURMON_BIT] = s_q.curmon;
					s_d.dat[pmt_pkg::CTRL_WKTMR_BIT] = s_q.wktmr_en;
					s_d.dat[pmt_pkg::CTRL_KEEP_BIT] = s_q.keep_cfg;
					s_d.dat[pmt_pkg::CTRL_TRDEL_LSB +: pmt_pkg::TRDEL_W] =
						s_q.trdel;
				end
				pmt_pkg::ADR_CMD: begin
					s_d.dat[pmt_pkg::CMD_W-1:0] = s_q.cmd;
				end
				pmt_pkg::ADR_STAT: begin
					s_d.dat[pmt_pkg::STAT_STATE_LSB +: 3] = s_q.state;
					s_d.dat[pmt_pkg::STAT_FLTOK_BIT] =
						(s_q.flt_cnt == pmt_pkg::FLT_MIN_PERIODS);
					s_d.dat[pmt_pkg::STAT_CAUSE_LSB +: 2] = s_q.cause;
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers, frozen while the clock enable is low
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.state <= pmt_pkg::PMT_INIT;
			s_q.sel_sy <= pmt_pkg::SEL_SY_RST; // no false edge after reset
			s_q.curmon <= pmt_pkg::CURMON_RST;
			s_q.wktmr_en <= pmt_pkg::WKTMR_RST;
			s_q.keep_cfg <= pmt_pkg::KEEP_RST;
			s_q.trdel <= pmt_pkg::TRDEL_CODE_RST;
			s_q.cause <= pmt_pkg::CAUSE_NONE;
			s_q.sup_en <= 1'b1;
			s_q.regs_on <= 1'b1;
			s_q.keep_on <= 1'b1;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs straight from flops
	// ----------------------------------------------------------------
	assign wb_dat_o = s_q.dat;
	assign wb_ack_o = s_q.ack;
	assign reset_output_o = s_q.rst_out;
	assign safe_state_out_a_o = s_q.ssa;
	assign safe_state_out_b_o = s_q.ssb;
	assign alert_output_o = s_q.alert;
	assign supervision_en_o = s_q.sup_en;
	assign regulators_on_o = s_q.regs_on;
	assign keepalive_regulator_on_o = s_q.keep_on;

endmodule

// ==== common/pmt_pkg.sv ====
package pmt_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int TRDEL_STEP_NS = 100000; // 100 us per delay code step
	localparam int TRDEL_STEP_CYC = TRDEL_STEP_NS / CLK_PERIOD_NS;
	localparam int TRDEL_MIN_US = 100;
	localparam int TRDEL_MAX_US = 1600;
	localparam int TRDEL_DEF_US = 900;
	localparam int POR_DELAY_NS = 10000; // power-on reset delay
	localparam int POR_DELAY_CYC = POR_DELAY_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 20;
	localparam logic [1:0] FLT_MIN_PERIODS = 2'h3;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_CMD = 8'h04;
	localparam logic [7:0] ADR_STAT = 8'h08;

	// control register fields
	localparam int CTRL_CURMON_BIT = 0;
	localparam int CTRL_WKTMR_BIT = 1;
	localparam int CTRL_KEEP_BIT = 2;
	localparam int CTRL_TRDEL_LSB = 4;
	localparam int TRDEL_W = 4;
	localparam logic [3:0] TRDEL_CODE_RST = 4'(TRDEL_DEF_US / TRDEL_MIN_US - 1);
	localparam logic CURMON_RST = 1'h0;
	localparam logic WKTMR_RST = 1'h0;
	localparam logic KEEP_RST = 1'h0;
	// select pin idles high, so its sync chain resets high
	localparam logic [2:0] SEL_SY_RST = 3'h7;

	// pending command codes
	localparam int CMD_W = 3;
	localparam logic [2:0] CMD_NONE = 3'h0;
	localparam logic [2:0] CMD_SLEEP = 3'h1;
	localparam logic [2:0] CMD_STANDBY = 3'h2;
	localparam logic [2:0] CMD_NORMAL = 3'h3;
	localparam logic [2:0] CMD_WAKE = 3'h4;

	// status register fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_FLTOK_BIT = 4;
	localparam int STAT_CAUSE_LSB = 8;

	// abort causes, and a refused NORMAL command
	localparam logic [1:0] CAUSE_NONE = 2'h0;
	localparam logic [1:0] CAUSE_WAKE = 2'h1;
	localparam logic [1:0] CAUSE_CURRENT = 2'h2;
	localparam logic [1:0] CAUSE_REFUSED = 2'h3;

	typedef enum logic [2:0] {
		PMT_INIT,
		PMT_NORMAL,
		PMT_WAKE,
		PMT_TO_SLEEP,
		PMT_SLEEP,
		PMT_TO_STANDBY,
		PMT_STANDBY
	} pmt_state_t;

endpackage

// ==== tb/pmt_checker.sv ====
`timescale 1ns/10ps
module pmt_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic host_select_line_i,
	input wire logic reset_output_o,
	input wire logic safe_state_out_a_o,
	input wire logic safe_state_out_b_o,
	input wire logic alert_output_o,
	input wire logic supervision_en_o,
	input wire logic regulators_on_o
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_SAFE_PAIR: assert property (
		safe_state_out_a_o == safe_state_out_b_o)
		else $error("safe outputs differ");
	AST_SUPV_AFTER_SEL: assert property ($fell(supervision_en_o) |->
		$past(host_select_line_i) && !$past(host_select_line_i, 8))
		else $error("supervision stopped without select edge");
	AST_SUPV_SAFE: assert property ($fell(supervision_en_o) |->
		!safe_state_out_a_o) else $error("safe high in transition");
	AST_SAFE_RISE: assert property ($rose(safe_state_out_a_o) |->
		reset_output_o && supervision_en_o && $past(host_select_line_i))
		else $error("safe rose without reset high");
	AST_SAFE_IN_RESET: assert property (!reset_output_o |->
		!safe_state_out_a_o) else $error("safe high during reset");
	AST_REG_OFF: assert property ($fell(regulators_on_o) |->
		!reset_output_o && !supervision_en_o) else $error("regulators off early");
	AST_ALERT_PULSE: assert property (alert_output_o |=> !alert_output_o)
		else $error("alert longer than one cycle");
	AST_ALERT_WAKE: assert property (alert_output_o |->
		reset_output_o && !safe_state_out_a_o) else $error("alert outputs wrong");
	AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
		|=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack timing");
	cover property ($fell(regulators_on_o));
	cover property ($rose(safe_state_out_a_o));
	cover property (alert_output_o);
endmodule
bind pmt_power_mode_fsm pmt_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .host_select_line_i(host_select_line_i),
	.reset_output_o(reset_output_o),
	.safe_state_out_a_o(safe_state_out_a_o),
	.safe_state_out_b_o(safe_state_out_b_o),
	.alert_output_o(alert_output_o), .supervision_en_o(supervision_en_o),
	.regulators_on_o(regulators_on_o));

// ==== tb/pmt_host_model.sv ====
`timescale 1ns/10ps
module pmt_host_model (
	input wire logic clk_i,
	input wire logic frame_i,
	input wire logic tog_en_i,
	output logic sel_o,
	output logic tog_o
);
	logic [4:0] frm_q = 5'h00;
	logic [2:0] div_q = 3'h0;
	// ----------------------------------------------------------------
	// select idles high; a frame holds it low, its rise ends the frame
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (frame_i)
			frm_q <= 5'h10;
		else if (frm_q != 5'h00)
			frm_q <= frm_q - 5'h01;
		div_q <= div_q + 3'h1;
	end
	assign sel_o = (frm_q == 5'h00);
	// error pin serviced with a free toggle of period 8, not aligned
	assign tog_o = tog_en_i & div_q[2];
endmodule

// ==== tb/pmt_power_mode_fsm_tb.sv ====
`timescale 1ns/10ps
module pmt_power_mode_fsm_tb;
	localparam int STEP = 10;
	localparam int POR = 5;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic we = 1'h0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] dat;
	logic ack, sel, tog, reset_output, ssa, ssb, alert, supv, regs, keep;
	logic ewk = 1'h0;
	logic lwk = 1'h0;
	logic cur = 1'h1;
	logic rup = 1'h1;
	logic wtm = 1'h0;
	logic frame = 1'h0;
	logic ce = 1'h1;
	logic tog_en = 1'h0;
	int n_fail = 0;
	int tests_run = 0;
	int tr_cyc = 0;
	int n_alert = 0;
	// ----------------------------------------------------------------
	// clock, design, host
	// ----------------------------------------------------------------
	always #2 clk_i = ~clk_i;
	pmt_power_mode_fsm #(.TRDEL_STEP_CYCLES(STEP), .POR_DELAY_CYCLES(POR)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
		.host_select_line_i(sel), .edge_wake_input_i(ewk),
		.level_rouse_input_i(lwk), .cur_below_thr_i(cur),
		.fault_toggle_input_i(tog), .ctrl_reg_up_i(rup),
		.wake_timer_exp_i(wtm), .reset_output_o(reset_output),
		.safe_state_out_a_o(ssa), .safe_state_out_b_o(ssb),
		.alert_output_o(alert), .supervision_en_o(supv),
		.regulators_on_o(regs), .keepalive_regulator_on_o(keep));
	pmt_host_model u_host (.clk_i(clk_i), .frame_i(frame),
		.tog_en_i(tog_en), .sel_o(sel), .tog_o(tog));
	// transition cycles and alert pulses counted from the pins
	always @(posedge clk_i) begin
		tr_cyc <= tr_cyc + (!supv && regs && reset_output);
		n_alert <= n_alert + (alert === 1'h1);
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic complete_run();
		if (n_fail == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int t;
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'h1 && t < 64);
		q = dat;
		cyc <= 1'h0;
		stb <= 1'h0;
		if (t >= 64)
			n_fail++;
	endtask
	task automatic st(input logic [2:0] e, output logic [31:0] q);
		wb(1'h0, pmt_pkg::ADR_STAT, 32'h0, q);
		check(q[2:0], e, "state");
	endtask
	task automatic ctl(input logic [7:0] v);
		logic [31:0] q;
		wb(1'h1, pmt_pkg::ADR_CTRL, {24'h0, v}, q);
	endtask
	// post a command, then let the host end a frame
	task automatic cmd(input logic [2:0] c);
		logic [31:0] q;
		wb(1'h1, pmt_pkg::ADR_CMD, {29'h0, c}, q);
		frame <= 1'h1;
		@(posedge clk_i);
		frame <= 1'h0;
		repeat (26) @(posedge clk_i);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (30000) @(posedge clk_i);
		n_fail++;
		complete_run();
	end
	initial begin
		logic [31:0] q;
		logic [3:0] code;
		int b;
		void'($urandom(32'hBFD2EABD));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (POR + 6) @(posedge clk_i);
		check(reset_output, 1'h1, "rot");
		wb(1'h0, pmt_pkg::ADR_CTRL, 32'h0, q);
		check(q, 32'h80, "ctrl");
		wb(1'h0, 8'hFC, 32'h0, q);
		check(q, 32'h0, "unmapped");
		cmd(pmt_pkg::CMD_NORMAL);
		st(pmt_pkg::PMT_NORMAL, q);
		check({ssa, ssb, reset_output}, 3'h7, "normal");
		code = 4'($urandom_range(15));
		ctl({code, 4'h6});
		b = tr_cyc;
		cmd(pmt_pkg::CMD_STANDBY);
		repeat ((code + 1) * STEP + 4) @(posedge clk_i);
		b = tr_cyc - b - (code + 1) * STEP;
		check(b >= -2 && b <= 2, 1'h1, "delay");
		st(pmt_pkg::PMT_STANDBY, q);
		check({reset_output, regs, keep, ssa, supv}, 5'h04, "standby");
		rup <= 1'h0;
		wtm <= 1'h1;
		repeat (20) @(posedge clk_i);
		st(pmt_pkg::PMT_INIT, q);
		check({reset_output, regs, ssa}, 3'h2, "init");
		wtm <= 1'h0;
		rup <= 1'h1;
		repeat (POR + 4) @(posedge clk_i);
		check(reset_output, 1'h1, "por");
		// aborts: standby then sleep, by wake edge and by current
		for (int k = 0; k < 4; k++) begin
			if (k < 2)
				cmd(pmt_pkg::CMD_NORMAL);
			ctl({4'h4, 3'h0, k[0]});
			cur <= !k[0];
			rup <= 1'h0;
			b = n_alert;
			cmd(k[1] ? pmt_pkg::CMD_SLEEP : pmt_pkg::CMD_STANDBY);
			ewk <= !k[0];
			// frozen clock enable must hold off the current timeout
			if (k == 3) begin
				ce <= 1'h0;
				repeat (60) @(posedge clk_i);
				check({supv, 31'(n_alert - b)}, 32'h0, "frozen");
				ce <= 1'h1;
			end
			repeat (60) @(posedge clk_i);
			st(k[1] ? pmt_pkg::PMT_WAKE : pmt_pkg::PMT_INIT, q);
			check({q[9:8], reset_output, 29'(n_alert - b)},
				{2'(k % 2 + 1), k[1], 29'(k[1])}, "abort");
			ewk <= 1'h0;
			cur <= 1'h1;
			rup <= 1'h1;
			repeat (POR + 4) @(posedge clk_i);
			if (k == 1) begin
				cmd(pmt_pkg::CMD_NORMAL);
				cmd(pmt_pkg::CMD_SLEEP);
				st(pmt_pkg::PMT_SLEEP, q);
				cmd(pmt_pkg::CMD_WAKE);
				ewk <= 1'h1;
				lwk <= 1'h1;
				cmd(pmt_pkg::CMD_NORMAL);
				st(pmt_pkg::PMT_WAKE, q);
				check(q[9:8], 2'h3, "refused");
				ewk <= 1'h0;
				lwk <= 1'h0;
			end
		end
		tog_en <= 1'h1;
		repeat (40) @(posedge clk_i);
		wb(1'h0, pmt_pkg::ADR_STAT, 32'h0, q);
		check(q[4], 1'h1, "toggles");
		cmd(pmt_pkg::CMD_NORMAL);
		st(pmt_pkg::PMT_NORMAL, q);
		check({ssa, ssb, reset_output}, 3'h7, "wake to normal");
		complete_run();
	end
endmodule
